/* ddr_diag.v */
// diagnostic reporting: state outputs, event latches, parameter port
`include "ddr_defines.vh"
`timescale 1ns/1ns
module ddr_diag #(
    parameter N_DQ = 2
) (
    // clock and reset
    input  wire            sys_clk,
    input  wire            reset,
    // drive state and events
    input  wire [3:0]      op_state,
    input  wire            diag_event,
    input  wire [15:0]     diag_number,
    input  wire [2:0]      diag_class,
    input  wire            fault_reset,
    // parameter request from the master
    input  wire            par_req,
    input  wire            par_wr,
    input  wire [15:0]     par_addr,
    input  wire [31:0]     par_wdata,
    // parameter answer
    output reg             par_ack,
    output reg             par_err,
    output reg  [31:0]     par_rdata,
    // unrequested error report
    output reg             report_valid,
    output reg  [15:0]     report_number,
    output reg  [2:0]      report_class,
    // indications
    output reg             no_fault_out,
    output reg             op_active_out,
    output reg             warn_flag,
    output reg             err_flag,
    output wire [N_DQ-1:0] digital_out
);

    // settings written by the master
    reg  [15:0] sel_warn_a;      // selected warning number a
    reg  [15:0] sel_warn_b;      // selected warning number b
    reg  [15:0] sel_err_a;       // selected error number a
    reg  [15:0] sel_err_b;       // selected error number b
    reg  [31:0] out_func;        // output function codes

    // latched diagnostic state
    reg  [15:0] last_warn;       // last warning number
    reg  [15:0] last_err;        // captured stopping error number
    reg         warn_seen;       // warning since fault reset
    reg         err_seen;        // error since fault reset
    reg         err_fatal;       // class 4 error, survives fault reset
    reg         sel_warn_hold;   // selected warning indication
    reg         sel_err_hold;    // selected error indication

    // error history bookkeeping
    reg  [3:0]  log_wp;          // next entry to write
    reg  [3:0]  log_fill;        // number of valid entries
    wire [31:0] log_rdata;       // registered memory data

    // request pipeline, first stage
    reg         req_q;           // a request was taken
    reg         bad_q;           // that request was refused
    reg         log_q;           // it addressed the history
    reg         log_empty_q;     // it addressed an unused entry
    reg  [15:0] addr_q;          // its address

    // decode helpers
    reg         adr_ok;
    reg         wr_ok;
    wire [15:0] log_off = par_addr - `DDR_ADR_LOG_BASE;
    wire        is_log  = log_off < {12'h000, `DDR_LOG_DEPTH};
    wire [3:0]  log_idx = log_off[3:0];
    wire [4:0]  log_sum = {1'b0, log_wp} + 5'h09 - {1'b0, log_idx};
    wire [4:0]  log_sub = log_sum - {1'b0, `DDR_LOG_DEPTH};
    wire [3:0]  log_ra  = (log_sum >= {1'b0, `DDR_LOG_DEPTH}) ? log_sub[3:0]
                                                              : log_sum[3:0];

    // event classification
    wire warn_ev = diag_event & (diag_class == `DDR_CLASS_WARN);
    wire err_ev  = diag_event & (diag_class != `DDR_CLASS_WARN);
    wire fatal   = diag_class == `DDR_CLASS_FATAL;

    // a zero selection never matches, so unset selections stay quiet
    wire warn_hit = warn_ev &
        (((sel_warn_a != 16'h0000) & (diag_number == sel_warn_a)) |
         ((sel_warn_b != 16'h0000) & (diag_number == sel_warn_b)));
    wire err_hit = err_ev &
        (((sel_err_a != 16'h0000) & (diag_number == sel_err_a)) |
         ((sel_err_b != 16'h0000) & (diag_number == sel_err_b)));

    // request validity and write enable
    wire bad_req = par_wr ? ~wr_ok : ~adr_ok;
    wire wr_en   = par_req & par_wr & wr_ok;

    // diagnostic number: error outranks warning
    wire [31:0] diag_word = err_seen  ? {12'h000, `DDR_KIND_ERR, last_err} :
                            warn_seen ? {12'h000, `DDR_KIND_WARN, last_warn} :
                                        32'h00000000;

    // status words
    reg  [31:0] stat_a;
    reg  [31:0] stat_b;

    // decode the address of the request now on the port
    always @* begin
        adr_ok = 1'b1;
        wr_ok  = 1'b0;
        case (par_addr)
            `DDR_ADR_SEL_WARN_A,
            `DDR_ADR_SEL_WARN_B,
            `DDR_ADR_SEL_ERR_A,
            `DDR_ADR_SEL_ERR_B: begin
                // values above 65535 are refused
                wr_ok = par_wdata[31:16] == 16'h0000;
            end
            `DDR_ADR_OUT_FUNC: begin
                wr_ok = 1'b1;
            end
            `DDR_ADR_LAST_ERR,
            `DDR_ADR_LAST_WARN,
            `DDR_ADR_DIAG_NUM,
            `DDR_ADR_STAT_A,
            `DDR_ADR_STAT_B: begin
                wr_ok = 1'b0;                                 // read only
            end
            default: begin
                adr_ok = is_log;                              // history read only
            end
        endcase
    end

    // status words built from the sticky flags
    always @* begin
        stat_a = 32'h00000000;
        stat_b = 32'h00000000;
        stat_a[`DDR_STA_WARN_BIT] = warn_seen;
        stat_a[`DDR_STA_ERR_BIT]  = err_seen;
        stat_b[`DDR_STB_WARN_BIT] = warn_seen;
        stat_b[`DDR_STB_ERR_BIT]  = err_seen;
    end

    // master writes take effect on the edge that takes them
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sel_warn_a <= `DDR_SEL_RST;
            sel_warn_b <= `DDR_SEL_RST;
            sel_err_a  <= `DDR_SEL_RST;
            sel_err_b  <= `DDR_SEL_RST;
            out_func   <= `DDR_OUT_FUNC_RST;
        end else if (wr_en) begin
            case (par_addr)
                `DDR_ADR_SEL_WARN_A: sel_warn_a <= par_wdata[15:0];
                `DDR_ADR_SEL_WARN_B: sel_warn_b <= par_wdata[15:0];
                `DDR_ADR_SEL_ERR_A:  sel_err_a  <= par_wdata[15:0];
                `DDR_ADR_SEL_ERR_B:  sel_err_b  <= par_wdata[15:0];
                `DDR_ADR_OUT_FUNC:   out_func   <= par_wdata;
                default:             out_func   <= out_func;
            endcase
        end
    end

    // warning latch: a new warning wins over a fault reset
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_warn <= 16'h0000;
            warn_seen <= 1'b0;
        end else if (warn_ev) begin
            last_warn <= diag_number;
            warn_seen <= 1'b1;
        end else if (fault_reset) begin
            last_warn <= 16'h0000;
            warn_seen <= 1'b0;
        end
    end

    // error capture: first stopping error kept, class 4 always overwrites
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_err  <= 16'h0000;
            err_seen  <= 1'b0;
            err_fatal <= 1'b0;
        end else if (err_ev) begin
            if (~err_seen | fatal) begin
                last_err <= diag_number;
            end
            err_seen  <= 1'b1;
            err_fatal <= err_fatal | fatal;
        end else if (fault_reset & ~err_fatal) begin
            // a class 4 error only goes away with power
            last_err <= 16'h0000;
            err_seen <= 1'b0;
        end
    end

    // selected indications hold until fault reset; a hit wins
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sel_warn_hold <= 1'b0;
            sel_err_hold  <= 1'b0;
        end else begin
            if (warn_hit) begin
                sel_warn_hold <= 1'b1;
            end else if (fault_reset) begin
                sel_warn_hold <= 1'b0;
            end
            if (err_hit) begin
                sel_err_hold <= 1'b1;
            end else if (fault_reset) begin
                sel_err_hold <= 1'b0;
            end
        end
    end

    // error history pointer and fill count
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            log_wp   <= 4'h0;
            log_fill <= 4'h0;
        end else if (err_ev) begin
            log_wp <= (log_wp == `DDR_LOG_DEPTH - 4'h1) ? 4'h0 : log_wp + 4'h1;
            if (log_fill != `DDR_LOG_DEPTH) begin
                log_fill <= log_fill + 4'h1;
            end
        end
    end

    // history storage, newest entry at offset 0
    ddr_err_mem #(
        .DEPTH (10),
        .AW    (4),
        .DW    (32)
    ) u_log (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wr_en   (err_ev),
        .wr_addr (log_wp),
        .wr_data ({8'h00, op_state, 1'b0, diag_class, diag_number}),
        .rd_addr (log_ra),
        .rd_data (log_rdata)
    );

    // first request stage, waits for the history read
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            req_q       <= 1'b0;
            bad_q       <= 1'b0;
            log_q       <= 1'b0;
            log_empty_q <= 1'b0;
            addr_q      <= 16'h0000;
        end else begin
            req_q       <= par_req;
            bad_q       <= bad_req;
            log_q       <= is_log;
            log_empty_q <= log_idx >= log_fill;
            addr_q      <= par_addr;
        end
    end

    // answer stage, one answer per request, two edges after it
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            par_ack   <= 1'b0;
            par_err   <= 1'b0;
            par_rdata <= 32'h00000000;
        end else begin
            par_ack <= req_q;
            par_err <= req_q & bad_q;
            if (~req_q | bad_q) begin
                par_rdata <= 32'h00000000;
            end else if (log_q) begin
                par_rdata <= log_empty_q ? 32'h00000000 : log_rdata;
            end else begin
                case (addr_q)
                    `DDR_ADR_LAST_WARN:  par_rdata <= {16'h0000, last_warn};
                    `DDR_ADR_LAST_ERR:   par_rdata <= {16'h0000, last_err};
                    `DDR_ADR_SEL_WARN_A: par_rdata <= {16'h0000, sel_warn_a};
                    `DDR_ADR_SEL_WARN_B: par_rdata <= {16'h0000, sel_warn_b};
                    `DDR_ADR_SEL_ERR_A:  par_rdata <= {16'h0000, sel_err_a};
                    `DDR_ADR_SEL_ERR_B:  par_rdata <= {16'h0000, sel_err_b};
                    `DDR_ADR_OUT_FUNC:   par_rdata <= out_func;
                    `DDR_ADR_DIAG_NUM:   par_rdata <= diag_word;
                    `DDR_ADR_STAT_A:     par_rdata <= stat_a;
                    `DDR_ADR_STAT_B:     par_rdata <= stat_b;
                    default:             par_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // unrequested report of each stopping error
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            report_valid  <= 1'b0;
            report_number <= 16'h0000;
            report_class  <= 3'h0;
        end else begin
            report_valid <= err_ev;
            if (err_ev) begin
                report_number <= diag_number;
                report_class  <= diag_class;
            end
        end
    end

    // state indications and status flags
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            no_fault_out  <= 1'b0;
            op_active_out <= 1'b0;
            warn_flag     <= 1'b0;
            err_flag      <= 1'b0;
        end else begin
            no_fault_out  <= (op_state == `DDR_ST_READY) |
                             (op_state == `DDR_ST_ON) |
                             (op_state == `DDR_ST_ENABLED);
            op_active_out <= op_state == `DDR_ST_ENABLED;
            warn_flag     <= warn_seen;
            err_flag      <= err_seen;
        end
    end

    // digital outputs, sources taken one cycle before the map register
    ddr_out_map #(
        .N_DQ (N_DQ)
    ) u_map (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .out_func    (out_func),
        .no_fault    (no_fault_out),
        .op_active   (op_active_out),
        .sel_warn    (sel_warn_hold),
        .sel_err     (sel_err_hold),
        .digital_out (digital_out)
    );

endmodule

/* ddr_defines.vh */
// constants for the drive diagnostic reporting block
// How it works
// - no fault in 4..6, active only 6
// - factory outputs: 0 no fault, 1 active
// - matching warning or error sets selected outputs
// - four 16-bit selections, default 0, live
// - last warning held until fault reset
// - last warning reads 0 when none
// - first stopping error captured, later ones ignored unless class 4
// - class 4 error overwrites captured number
// - last error 0 when none; log errors
// - status bits 6,7 and 12,13 flag events
// - errors reported to master unrequested
// - bad master request answers with error
// - current event number readable as diagnostic
// - class 0 is warning, 1..4 errors
// - diagnostic: number, kind 14/15, rest reserved
`ifndef DDR_DEFINES_VH
`define DDR_DEFINES_VH

// parameter addresses
`define DDR_ADR_LAST_ERR   16'h1C0A
`define DDR_ADR_LAST_WARN  16'h1C12
`define DDR_ADR_SEL_ERR_A  16'h3B0C
`define DDR_ADR_SEL_ERR_B  16'h3B0E
`define DDR_ADR_SEL_WARN_A 16'h3B10
`define DDR_ADR_SEL_WARN_B 16'h3B12
`define DDR_ADR_DIAG_NUM   16'h0390
`define DDR_ADR_STAT_A     16'h1045
`define DDR_ADR_STAT_B     16'h0135
`define DDR_ADR_OUT_FUNC   16'h3B20
`define DDR_ADR_LOG_BASE   16'h1D00
`define DDR_LOG_DEPTH      4'hA

// reset values
`define DDR_SEL_RST        16'h0000
`define DDR_OUT_FUNC_RST   32'h00000011

// status and diagnostic field positions
`define DDR_STA_WARN_BIT   6
`define DDR_STA_ERR_BIT    7
`define DDR_STB_WARN_BIT   12
`define DDR_STB_ERR_BIT    13
`define DDR_KIND_WARN      4'hE
`define DDR_KIND_ERR       4'hF

// output function codes, three bits per output
`define DDR_FN_NONE        3'h0
`define DDR_FN_NO_FAULT    3'h1
`define DDR_FN_ACTIVE      3'h2
`define DDR_FN_SEL_WARN    3'h3
`define DDR_FN_SEL_ERR     3'h4

// operating states and error classes
`define DDR_ST_READY       4'h4
`define DDR_ST_ON          4'h5
`define DDR_ST_ENABLED     4'h6
`define DDR_CLASS_WARN     3'h0
`define DDR_CLASS_FATAL    3'h4

`endif

/* ddr_err_mem.v */
// error history memory with registered read data
`timescale 1ns/1ns
module ddr_err_mem #(
    parameter DEPTH = 10,
    parameter AW    = 4,
    parameter DW    = 32
) (
    // clock and reset
    input  wire          sys_clk,
    input  wire          reset,
    // write side
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // read side
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

    // storage has no reset; unwritten entries are masked by the fill count
    reg [DW-1:0] mem [0:DEPTH-1];

    // write port
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data always come from a register
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data <= {DW{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

/* ddr_out_map.v */
// maps indication functions onto the digital outputs
`include "ddr_defines.vh"
`timescale 1ns/1ns
module ddr_out_map #(
    parameter N_DQ = 2
) (
    // clock and reset
    input  wire            sys_clk,
    input  wire            reset,
    // function selection, three bits per output
    input  wire [31:0]     out_func,
    // indication sources
    input  wire            no_fault,
    input  wire            op_active,
    input  wire            sel_warn,
    input  wire            sel_err,
    // outputs
    output reg  [N_DQ-1:0] digital_out
);

    genvar i;
    // one registered selector per output
    generate
        for (i = 0; i < N_DQ; i = i + 1) begin : g_dq
            wire [2:0] fn = out_func[3*i+2:3*i];
            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    digital_out[i] <= 1'b0;
                end else begin
                    case (fn)
                        `DDR_FN_NO_FAULT: digital_out[i] <= no_fault;
                        `DDR_FN_ACTIVE:   digital_out[i] <= op_active;
                        `DDR_FN_SEL_WARN: digital_out[i] <= sel_warn;
                        `DDR_FN_SEL_ERR:  digital_out[i] <= sel_err;
                        default:          digital_out[i] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

endmodule

/* ddr_diag_asserts.sv */
// checker for the diagnostic reporting block, bound to its top module
`timescale 1ns/1ns
module ddr_diag_asserts (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    // drive state and events
    input  wire [3:0]  op_state,
    input  wire        diag_event,
    input  wire [15:0] diag_number,
    input  wire [2:0]  diag_class,
    // parameter port
    input  wire        par_req,
    input  wire        par_ack,
    input  wire        par_err,
    input  wire [31:0] par_rdata,
    // reports and indications
    input  wire        report_valid,
    input  wire [15:0] report_number,
    input  wire        no_fault_out,
    input  wire        op_active_out,
    input  wire        warn_flag,
    input  wire        err_flag
);
    // one domain, so clock and reset are given once here
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // two clean edges needed, outputs are held at 0 just after release
    a_no_fault_state: assert property (
        !$past(reset) && !$past(reset, 2) |->
        no_fault_out == ($past(op_state) >= 4'h4 && $past(op_state) <= 4'h6))
        else $error("no fault output does not follow state");
    a_active_state: assert property (
        !$past(reset) && !$past(reset, 2) |-> op_active_out == ($past(op_state) == 4'h6))
        else $error("active output does not follow state");
    a_ack_latency: assert property (par_req |-> ##2 par_ack)
        else $error("request not answered two edges later");
    a_ack_stray: assert property (par_ack |-> $past(par_req, 2))
        else $error("answer without request");
    a_err_with_ack: assert property (par_err |-> par_ack)
        else $error("refusal outside an answer");
    a_rdata_idle: assert property (!par_ack |-> par_rdata == 32'h00000000)
        else $error("read data not zero between answers");
    // flags copy the sticky latches, so they rise one edge after the report
    a_error_report: assert property (
        diag_event && diag_class != 3'h0 |=>
        report_valid && report_number == $past(diag_number) ##1 err_flag)
        else $error("error not reported unrequested");
    a_warn_no_report: assert property (
        diag_event && diag_class == 3'h0 |=> !report_valid ##1 warn_flag)
        else $error("warning handled as error");
endmodule

bind ddr_diag ddr_diag_asserts chk_u (
    .sys_clk(sys_clk), .reset(reset), .op_state(op_state), .diag_event(diag_event),
    .diag_number(diag_number), .diag_class(diag_class), .par_req(par_req),
    .par_ack(par_ack), .par_err(par_err), .par_rdata(par_rdata),
    .report_valid(report_valid), .report_number(report_number),
    .no_fault_out(no_fault_out), .op_active_out(op_active_out),
    .warn_flag(warn_flag), .err_flag(err_flag)
);

/* ddr_master.sv */
// fieldbus master model issuing parameter requests
`timescale 1ns/1ns
module ddr_master (
    // clock
    input  wire         sys_clk,
    // request
    output logic        par_req,
    output logic        par_wr,
    output logic [15:0] par_addr,
    output logic [31:0] par_wdata,
    // answer
    input  wire         par_ack,
    input  wire         par_err,
    input  wire  [31:0] par_rdata
);
    // idle at time zero, nothing pending
    initial begin
        par_req   = 1'b0;
        par_wr    = 1'b0;
        par_addr  = 16'h0000;
        par_wdata = 32'h00000000;
    end

    // entered just after an edge, returns just after the answer edge
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        par_req   = 1'b1;
        par_wr    = wr;
        par_addr  = addr;
        par_wdata = wdata;
        @(posedge sys_clk);
        #1;
        // released lines carry garbage so stale values are never trusted
        par_req   = 1'b0;
        par_addr  = ~addr;
        par_wdata = ~wdata;
        while (par_ack !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        rdata = par_rdata;
        // a missing answer poisons the refusal flag so every compare of it fails
        err   = (n < 4) ? par_err : 1'bx;
    endtask
endmodule

/* ddr_tb.sv */
// self-checking bench for the diagnostic reporting block
`timescale 1ns/1ns
`define DDR_CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    logic        sys_clk;
    logic        reset;
    logic [3:0]  op_state;
    logic        diag_event;
    logic [15:0] diag_number;
    logic [2:0]  diag_class;
    logic        fault_reset;
    wire         par_req, par_wr, par_ack, par_err;
    wire  [15:0] par_addr;
    wire  [31:0] par_wdata, par_rdata;
    wire         report_valid, no_fault_out, op_active_out, warn_flag, err_flag;
    wire  [15:0] report_number;
    wire  [2:0]  report_class;
    wire  [1:0]  digital_out;
    logic [31:0] rv;           // last read data
    logic        re;           // last refusal flag
    int          tests_run;
    int          miscompares;
    int          cycles;

    ddr_diag dut_u (.sys_clk(sys_clk), .reset(reset), .op_state(op_state),
        .diag_event(diag_event), .diag_number(diag_number), .diag_class(diag_class),
        .fault_reset(fault_reset), .par_req(par_req), .par_wr(par_wr), .par_addr(par_addr),
        .par_wdata(par_wdata), .par_ack(par_ack), .par_err(par_err), .par_rdata(par_rdata),
        .report_valid(report_valid), .report_number(report_number),
        .report_class(report_class), .no_fault_out(no_fault_out),
        .op_active_out(op_active_out), .warn_flag(warn_flag), .err_flag(err_flag),
        .digital_out(digital_out));
    ddr_master master_u (.sys_clk(sys_clk), .par_req(par_req), .par_wr(par_wr),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_ack(par_ack), .par_err(par_err),
        .par_rdata(par_rdata));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task test_done;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic rd(input logic [15:0] a);
        master_u.access(1'b0, a, 32'h00000000, rv, re);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        master_u.access(1'b1, a, d, rv, re);
    endtask

    // one event pulse, returns once the selected outputs have settled
    task automatic ev(input logic [15:0] n, input logic [2:0] c);
        diag_event  = 1'b1;
        diag_number = n;
        diag_class  = c;
        @(posedge sys_clk);
        #1;
        diag_event  = 1'b0;
        diag_number = ~n;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task t_reset;
        rd(16'h1C12);
        `DDR_CHK(rv, 32'h00000000)
        rd(16'h1C0A);
        `DDR_CHK(rv, 32'h00000000)
        rd(16'h0390);
        `DDR_CHK(rv, 32'h00000000)
        for (int i = 0; i < 4; i++) begin
            rd(16'h3B0C + 16'(2 * i));
            `DDR_CHK(rv, 32'h00000000)
        end
        $display("test reset values done");
    endtask

    // walk states 1 to 9 with the factory output map
    task t_states;
        for (int s = 1; s <= 9; s++) begin
            op_state = 4'(s);
            repeat (3) @(posedge sys_clk);
            #1;
            `DDR_CHK(no_fault_out, (s >= 4 && s <= 6))
            `DDR_CHK(op_active_out, (s == 6))
            `DDR_CHK(digital_out, {s == 6, s >= 4 && s <= 6})
        end
        $display("test state outputs done");
    endtask

    // selections: error a, error b, warning a left at 0, warning b
    task t_params;
        logic [15:0] sel_v [4];
        sel_v = '{16'h3333, 16'h7777, 16'h0000, 16'h1234};
        for (int i = 0; i < 4; i++) begin
            wr(16'h3B0C + 16'(2 * i), {16'h0000, sel_v[i]});
            `DDR_CHK(re, 1'b0)
            rd(16'h3B0C + 16'(2 * i));
            `DDR_CHK(rv, {16'h0000, sel_v[i]})
        end
        wr(16'h3B0C, 32'h00010000);
        `DDR_CHK(re, 1'b1)
        rd(16'h3B0C);
        `DDR_CHK(rv, 32'h00003333)
        wr(16'h1C0A, 32'h00000005);
        `DDR_CHK(re, 1'b1)
        rd(16'h2000);
        `DDR_CHK({re, rv}, {1'b1, 32'h00000000})
        $display("test parameters done");
    endtask

    task t_warn;
        wr(16'h3B20, 32'h00000023);  // output 0 selected warning, output 1 selected error
        ev(16'h0000, 3'h0);
        `DDR_CHK(digital_out[0], 1'b0)
        ev(16'h1111, 3'h0);
        `DDR_CHK(digital_out[0], 1'b0)
        rd(16'h1C12);
        `DDR_CHK(rv, 32'h00001111)
        rd(16'h1045);
        `DDR_CHK(rv[7:6], 2'b01)
        rd(16'h0390);
        `DDR_CHK(rv, 32'h000E1111)
        ev(16'h1234, 3'h0);
        `DDR_CHK(digital_out[0], 1'b1)
        $display("test warnings done");
    endtask

    task t_err;
        fault_reset = 1'b1;
        @(posedge sys_clk);
        #1;
        fault_reset = 1'b0;
        rd(16'h1C12);
        `DDR_CHK(rv, 32'h00000000)
        ev(16'h2222, 3'h2);
        `DDR_CHK(digital_out[1], 1'b0)
        rd(16'h1C0A);
        `DDR_CHK(rv, 32'h00002222)
        ev(16'h3333, 3'h1);
        `DDR_CHK(digital_out[1], 1'b1)
        `DDR_CHK(report_number, 16'h3333)
        `DDR_CHK(report_class, 3'h1)
        rd(16'h1C0A);
        `DDR_CHK(rv, 32'h00002222)
        ev(16'h4444, 3'h4);
        rd(16'h1C0A);
        `DDR_CHK(rv, 32'h00004444)
        rd(16'h0135);
        `DDR_CHK(rv[13:12], 2'b10)
        rd(16'h0390);
        `DDR_CHK(rv, 32'h000F4444)
        rd(16'h1D00);
        `DDR_CHK(rv[18:0], {3'h4, 16'h4444})
        // oldest of three entries, then the first unused one
        rd(16'h1D02);
        `DDR_CHK(rv[18:0], {3'h2, 16'h2222})
        rd(16'h1D03);
        `DDR_CHK(rv, 32'h00000000)
        $display("test errors done");
    endtask

    // reset, then the scenarios in order
    initial begin
        tests_run   = 0;
        miscompares = 0;
        cycles      = 0;
        reset       = 1'b1;
        op_state    = 4'h1;
        diag_event  = 1'b0;
        diag_number = 16'h0000;
        diag_class  = 3'h0;
        fault_reset = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_states();
        t_params();
        t_warn();
        t_err();
        test_done();
    end
endmodule
